/* verilog/iirp_map.svh */
`ifndef IIRP_MAP_SVH
`define IIRP_MAP_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define IIRP_NUM_LEVELS       4
`define IIRP_NUM_RTC          4

// ----------------------------------------------------------------------------
// Timing, clock at 250 MHz
// ----------------------------------------------------------------------------
`define IIRP_CLK_PERIOD_PS    4000
`define IIRP_RTC_MIN_PULSE_PS 50000
`define IIRP_RTC_GAP_PS       3600000
// Least times round up to whole cycles
`define IIRP_RTC_PULSE_CYC    ((`IIRP_RTC_MIN_PULSE_PS + `IIRP_CLK_PERIOD_PS - 1) / `IIRP_CLK_PERIOD_PS)
`define IIRP_RTC_GAP_CYC      ((`IIRP_RTC_GAP_PS + `IIRP_CLK_PERIOD_PS - 1) / `IIRP_CLK_PERIOD_PS)
// Request width of 2.5 logic clocks, rounded up; the +2 covers the synchroniser
`define IIRP_REQ_MIN_CYC      8'h05

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define IIRP_RST_LEVELS       4'h0
`define IIRP_RST_SYNC         4'hF

`endif

/* verilog/iirp_pkg.sv */
package iirp_pkg;
   typedef logic [3:0] iirp_vec_t;
   typedef enum logic [1:0] {
      IIRP_LV_IDLE = 2'b00,
      IIRP_LV_REQ  = 2'b01,
      IIRP_LV_WAIT = 2'b10
   } iirp_host_state_t;
endpackage

/* verilog/iirp_if.sv */
`timescale 1ns/10ps
interface iirp_if;
   logic [3:0] rtc_pulse;
   logic [3:0] level_req;
   logic [3:0] level_ack;

   modport device (
      input  rtc_pulse,
      input  level_req,
      output level_ack
   );
   modport user (
      output rtc_pulse,
      output level_req,
      input  level_ack
   );
endinterface

/* verilog/iirp_device.sv */
`timescale 1ns/10ps
`include "iirp_map.svh"
module iirp_device
   import iirp_pkg::*;
(
   input  wire logic      clk_i,
   input  wire logic      sys_rst_i,
   iirp_if.device         bus,
   input  wire iirp_vec_t arm_i,
   input  wire iirp_vec_t done_i,
   output iirp_vec_t      rtc_event_o,
   output iirp_vec_t      level_pending_o,
   output iirp_vec_t      armed_o
);
   // ------------------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------------------
   iirp_vec_t rtc_s1_reg, rtc_s2_reg, rtc_s3_reg;
   iirp_vec_t req_s1_reg, req_s2_reg, req_s3_reg;
   iirp_vec_t armed_reg, ack_reg, rtc_event_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rtc_s1_reg <= `IIRP_RST_SYNC;
         rtc_s2_reg <= `IIRP_RST_SYNC;
         rtc_s3_reg <= `IIRP_RST_SYNC;
      end else begin
         rtc_s1_reg <= bus.rtc_pulse;
         rtc_s2_reg <= rtc_s1_reg;
         rtc_s3_reg <= rtc_s2_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         req_s1_reg <= `IIRP_RST_LEVELS;
         req_s2_reg <= `IIRP_RST_LEVELS;
         req_s3_reg <= `IIRP_RST_LEVELS;
      end else begin
         req_s1_reg <= bus.level_req;
         req_s2_reg <= req_s1_reg;
         req_s3_reg <= req_s2_reg;
      end
   end

   // ------------------------------------------------------------------------
   // Clock pulse edges
   // ------------------------------------------------------------------------
   // Falling edge only; pulse length plays no part
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rtc_event_reg <= `IIRP_RST_LEVELS;
      end else begin
         rtc_event_reg <= rtc_s3_reg & ~rtc_s2_reg;
      end
   end

   // ------------------------------------------------------------------------
   // Level request, arm and response
   // ------------------------------------------------------------------------
   // Rising request edge; a level still held high cannot retrigger
   iirp_vec_t req_rise;
   assign req_rise = req_s2_reg & ~req_s3_reg;

   genvar g;
   generate
      for (g = 0; g < `IIRP_NUM_LEVELS; g++) begin : g_level
         always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
               armed_reg[g] <= 1'b0;
               ack_reg[g]   <= 1'b0;
            end else if (req_rise[g] && armed_reg[g] && !ack_reg[g]) begin
               // Accepted: busy until the routine ends
               armed_reg[g] <= 1'b0;
               ack_reg[g]   <= 1'b1;
            end else if (ack_reg[g]) begin
               // Hold response until service finished
               // Requests seen now are dropped silently
               if (done_i[g]) begin
                  ack_reg[g]   <= 1'b0;
                  armed_reg[g] <= arm_i[g];
               end
            end else if (arm_i[g]) begin
               armed_reg[g] <= 1'b1;
            end
         end
      end
   endgenerate

   assign bus.level_ack     = ack_reg;
   assign rtc_event_o       = rtc_event_reg;
   assign level_pending_o   = ack_reg;
   assign armed_o           = armed_reg;
endmodule // iirp_device

/* verilog/iirp_user.sv */
`timescale 1ns/10ps
`include "iirp_map.svh"
module iirp_user
   import iirp_pkg::*;
(
   input  wire logic      clk_i,
   input  wire logic      sys_rst_i,
   iirp_if.user           bus,
   input  wire iirp_vec_t rtc_tick_i,
   input  wire iirp_vec_t level_start_i,
   output iirp_vec_t      level_busy_o,
   output iirp_vec_t      rtc_busy_o
);
   localparam int PW = `IIRP_RTC_PULSE_CYC;
   localparam int GW = `IIRP_RTC_GAP_CYC;

   iirp_vec_t ack_s1_reg, ack_s2_reg, req_reg, rtc_reg, rtc_busy_reg;
   iirp_host_state_t st_reg [4];

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ack_s1_reg <= `IIRP_RST_LEVELS;
         ack_s2_reg <= `IIRP_RST_LEVELS;
      end else begin
         ack_s1_reg <= bus.level_ack;
         ack_s2_reg <= ack_s1_reg;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_ch
         logic [7:0]  hold_reg;
         logic [11:0] rtc_cnt_reg;
         // Low pulse of 50 ns then a gap covering service time
         always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
               rtc_reg[g]      <= 1'b1;
               rtc_busy_reg[g] <= 1'b0;
               rtc_cnt_reg     <= 12'h000;
            end else if (!rtc_busy_reg[g]) begin
               if (rtc_tick_i[g]) begin
                  rtc_reg[g]      <= 1'b0;
                  rtc_busy_reg[g] <= 1'b1;
                  rtc_cnt_reg     <= 12'h000;
               end
            end else begin
               rtc_cnt_reg <= rtc_cnt_reg + 12'h001;
               if (rtc_cnt_reg == 12'(PW - 1)) begin
                  rtc_reg[g] <= 1'b1;
               end
               if (rtc_cnt_reg == 12'(GW - 1)) begin
                  rtc_busy_reg[g] <= 1'b0;
               end
            end
         end
         // Request held a minimum width, then dropped without waiting for the response
         always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
               st_reg[g]  <= IIRP_LV_IDLE;
               req_reg[g] <= 1'b0;
               hold_reg   <= 8'h00;
            end else begin
               unique case (st_reg[g])
                  IIRP_LV_IDLE: begin
                     if (level_start_i[g] && !ack_s2_reg[g]) begin
                        req_reg[g] <= 1'b1;
                        hold_reg   <= 8'h00;
                        st_reg[g]  <= IIRP_LV_REQ;
                     end
                  end
                  IIRP_LV_REQ: begin
                     hold_reg <= hold_reg + 8'h01;
                     if (hold_reg >= `IIRP_REQ_MIN_CYC) begin
                        req_reg[g] <= 1'b0;
                        st_reg[g]  <= IIRP_LV_WAIT;
                     end
                  end
                  IIRP_LV_WAIT: begin
                     if (!ack_s2_reg[g]) begin
                        st_reg[g] <= IIRP_LV_IDLE;
                     end
                  end
                  default: begin
                     st_reg[g] <= IIRP_LV_IDLE;
                  end
               endcase
            end
         end
         assign level_busy_o[g] = (st_reg[g] != IIRP_LV_IDLE) | ack_s2_reg[g];
      end
   endgenerate

   assign bus.rtc_pulse = rtc_reg;
   assign bus.level_req = req_reg;
   assign rtc_busy_o    = rtc_busy_reg;
endmodule // iirp_user

/* verification/iirp_checker.sv */
`timescale 1ns/10ps
`include "iirp_map.svh"
module iirp_checker (
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic [3:0] rtc_pulse_i,
   input  wire logic [3:0] level_req_i,
   input  wire logic [3:0] level_ack_i
);
   // Counter starts at zero on a fall, so the floor is one below the gap
   localparam int GAP_MIN = `IIRP_RTC_GAP_CYC - 1;

   // ------------------------------------------------------------------
   // Wire rules: one reset check over all four pins, then one set per level
   // ------------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_idle_after_rst: assert property ($fell(sys_rst_i) |-> rtc_pulse_i == 4'hF)
      else $error("clock pins not idle high after reset");
   for (genvar n = 0; n < 4; n++) begin : g_lv
      logic [11:0] gap_cnt;
      logic        fell_once;
      // Saturates so a long quiet spell never wraps into a short one
      always_ff @(posedge clk_i) begin
         if (sys_rst_i) begin
            gap_cnt   <= 12'h000;
            fell_once <= 1'b0;
         end else if ($fell(rtc_pulse_i[n])) begin
            gap_cnt   <= 12'h000;
            fell_once <= 1'b1;
         end else if (gap_cnt != 12'hFFF) begin
            gap_cnt <= gap_cnt + 12'h001;
         end
      end
      sequence s_req_up;
         $rose(level_req_i[n]);
      endsequence
      // 50 ns needs thirteen low samples at 4 ns
      sequence s_rtc_low;
         !rtc_pulse_i[n] [*8] ##1 !rtc_pulse_i[n] [*5];
      endsequence
      a_ack_has_req: assert property ($rose(level_ack_i[n]) |-> $past(level_req_i[n], 2))
         else $error("response rose without request");
      // Two sync stages mean no response on the next two edges
      a_sync_delay: assert property (
         s_req_up |=> !$rose(level_ack_i[n]) ##1 !$rose(level_ack_i[n]))
         else $error("response came too soon");
      a_req_min_width: assert property (s_req_up |-> level_req_i[n] [*3])
         else $error("request too short");
      a_req_waits_ack: assert property (s_req_up |-> !level_ack_i[n])
         else $error("request while response true");
      a_req_gone_end: assert property ($fell(level_ack_i[n]) |-> !level_req_i[n])
         else $error("request still up at end of service");
      a_rtc_low_width: assert property ($fell(rtc_pulse_i[n]) |-> s_rtc_low)
         else $error("clock pulse too narrow");
      a_rtc_gap_held: assert property (
         $fell(rtc_pulse_i[n]) && fell_once |-> gap_cnt >= 12'(GAP_MIN))
         else $error("clock edges too close");
   end
endmodule // iirp_checker

/* verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
   import iirp_pkg::*;
   logic      clk_i = 1'b0;
   logic      sys_rst_i = 1'b1;
   iirp_vec_t arm_a = 4'h0, done_a = 4'h0, arm_b = 4'h0, done_b = 4'h0;
   iirp_vec_t tick = 4'h0, start = 4'h0;
   iirp_vec_t ev_a, ev_b, pend_a, pend_b, busy_l, busy_r, armed_a;
   int        n_errors = 0, comparisons = 0, n_full = 0, n_b = 0;
   // ------------------------------------------------------------------
   // Two ends face to face; a second device is driven by hand
   // ------------------------------------------------------------------
   iirp_if bus_a ();
   iirp_if bus_b ();
   iirp_device u_iirp_device (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(bus_a),
      .arm_i(arm_a), .done_i(done_a), .rtc_event_o(ev_a), .level_pending_o(pend_a),
      .armed_o(armed_a));
   iirp_user u_iirp_user (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(bus_a),
      .rtc_tick_i(tick), .level_start_i(start), .level_busy_o(busy_l), .rtc_busy_o(busy_r));
   iirp_device u_iirp_device_b (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(bus_b),
      .arm_i(arm_b), .done_i(done_b), .rtc_event_o(ev_b), .level_pending_o(pend_b), .armed_o());
   iirp_checker u_iirp_checker (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .rtc_pulse_i(bus_a.rtc_pulse), .level_req_i(bus_a.level_req),
      .level_ack_i(bus_a.level_ack));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   // Sampled mid-cycle, where the one-cycle event pulse has settled
   always @(negedge clk_i) begin
      if (ev_a == 4'hF) n_full++;
      if (ev_b[0] === 1'b1) n_b++;
   end
   task automatic check(input iirp_vec_t got, input iirp_vec_t exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Tests take about 1100 cycles, mostly the clock gap; the limit leaves wide room
   initial begin
      #80000;
      n_errors++;
      summarize();
   end
   initial begin
      bus_b.rtc_pulse = 4'hF;
      bus_b.level_req = 4'h0;
      wait_n(2);
      sys_rst_i = 1'b0;
      arm_a = 4'hF;
      wait_n(1);
      start = 4'hF;
      wait_n(1);
      start = 4'h0;
      wait_n(4);
      check(bus_a.level_ack, 4'hF);
      check(armed_a, 4'h0);
      arm_a = 4'h0;
      wait_n(12);
      check(pend_a, 4'hF);
      done_a = 4'hF;
      wait_n(1);
      done_a = 4'h0;
      wait_n(2);
      check(pend_a, 4'h0);
      check(armed_a, 4'h0);
      wait_n(8);
      check(busy_l, 4'h0);
      $display("test handshake done");
      start = 4'h5;
      wait_n(1);
      start = 4'h0;
      wait_n(12);
      check(pend_a, 4'h0);
      arm_a = 4'h5;
      start = 4'h5;
      wait_n(1);
      start = 4'h0;
      wait_n(4);
      check(pend_a, 4'h5);
      wait_n(8);
      done_a = 4'h5;
      wait_n(1);
      done_a = 4'h0;
      check(armed_a, 4'h5);
      $display("test arming done");
      tick = 4'hF;
      wait_n(1);
      tick = 4'h0;
      wait_n(30);
      check(iirp_vec_t'(n_full), 4'h1);
      check(bus_a.rtc_pulse, 4'hF);
      check(busy_r, 4'hF);
      tick = 4'hF;
      wait_n(1);
      tick = 4'h0;
      wait_n(20);
      check(iirp_vec_t'(n_full), 4'h1);
      wait_n(860);
      check(busy_r, 4'h0);
      tick = 4'hF;
      wait_n(1);
      tick = 4'h0;
      wait_n(30);
      check(iirp_vec_t'(n_full), 4'h2);
      bus_b.rtc_pulse = 4'hE;
      wait_n(40);
      bus_b.rtc_pulse = 4'hF;
      wait_n(10);
      check(iirp_vec_t'(n_b), 4'h1);
      $display("test clock done");
      arm_b = 4'h1;
      bus_b.level_req = 4'h1;
      wait_n(1);
      check(pend_b, 4'h0);
      wait_n(5);
      bus_b.level_req = 4'h0;
      check(pend_b, 4'h1);
      wait_n(3);
      bus_b.level_req = 4'h1;
      wait_n(6);
      bus_b.level_req = 4'h0;
      wait_n(3);
      done_b = 4'h1;
      wait_n(1);
      done_b = 4'h0;
      wait_n(10);
      check(pend_b, 4'h0);
      $display("test lost request done");
      summarize();
   end
endmodule // testbench
